/* File: rtl/pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  // Only the second stage reads the first one.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else if (i_ce) begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule // pin_sync
`default_nettype wire

/* File: rtl/spi_ref_mon_pkg.sv */
`default_nettype none
package spi_ref_mon_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_WIDTH = ADDR_W + DATA_W;
  localparam int unsigned FIFO_DEPTH = 16;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_CONFIG_A  = 7'h00;
  localparam logic [6:0] ADDR_CONFIG_B  = 7'h01;
  localparam logic [6:0] ADDR_REFERENCE = 7'h14;
  localparam logic [6:0] ADDR_MONITOR   = 7'h1A;
  localparam logic [6:0] ADDR_STATUS    = 7'h1B;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CFGA_DIR_HI_BIT  = 5;
  localparam int unsigned CFGA_DIR_LO_BIT  = 2;
  localparam int unsigned CFGB_SINGLE_BIT  = 7;
  localparam int unsigned REF_SEL_LSB      = 1;
  localparam int unsigned REF_RES_BIT      = 0;
  localparam int unsigned MON_FUNC_LSB     = 6;
  localparam int unsigned MON_BUF_BIT      = 5;
  localparam int unsigned MON_BIAS_BIT     = 4;
  localparam int unsigned MONITORED_CHANNEL_SELECT_LSB       = 0;
  localparam int unsigned STAT_FAULT_BIT   = 0;
  localparam int unsigned STAT_RES_EXT_BIT = 1;
  localparam int unsigned STAT_EMPTY_BIT   = 2;

  // ----------------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFGA_MASK  = 8'h24;
  localparam logic [7:0] CFGB_MASK  = 8'h80;
  localparam logic [7:0] REF_MASK   = 8'h07;
  localparam logic [7:0] MON_MASK   = 8'hF7;
  localparam logic [7:0] CFGA_RESET = 8'h00;
  localparam logic [7:0] CFGB_RESET = 8'h00;
  localparam logic [7:0] REF_RESET  = 8'h02;
  localparam logic [7:0] MON_RESET  = 8'h00;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    REF_EXT_1V25   = 2'h0,
    REF_EXT_2V5    = 2'h1,
    REF_INT_EXPORT = 2'h2,
    REF_INT_LOCAL  = 2'h3
  } ref_sel_t;

  typedef enum logic [1:0] {
    MON_OFF     = 2'h0,
    MON_VOLTAGE = 2'h1,
    MON_CURRENT = 2'h2,
    MON_TEMP    = 2'h3
  } mon_func_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_INSTR = 3'h2,
    ST_DATA  = 3'h4
  } spi_state_t;

endpackage
`default_nettype wire

/* File: rtl/spi_reference_monitor_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_reference_monitor_ctrl
  import spi_ref_mon_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic       i_cs_n,
  input  wire logic       i_sclk,
  input  wire logic       i_sdi,
  input  wire logic       i_rset_low_fault,
  input  wire logic       i_commit_hold,
  output logic            o_sdo,
  output logic            o_sdo_oe,
  output logic            o_wr_fifo_ready,
  output logic            o_internal_ref_enable,
  output logic            o_ref_output_switch,
  output logic            o_internal_ref_switch,
  output logic            o_divider_select_switch,
  output logic            o_resistor_select_switch,
  output logic            o_monitor_enable,
  output logic [1:0]      o_monitor_function_select,
  output logic [2:0]      o_monitored_channel_select,
  output logic            o_mux_buffer_enable,
  output logic            o_external_bias_enable
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [6:0] step_addr(input logic [6:0] addr,
                                           input logic       up);
    step_addr = up ? 7'(addr + 7'h01) : 7'(addr - 7'h01);
  endfunction

  function automatic logic is_internal(input logic [1:0] sel);
    is_internal = (sel == REF_INT_EXPORT) || (sel == REF_INT_LOCAL);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  wire  [3:0] pins_sync;
  wire        cs_n_s;
  wire        sclk_s;
  wire        sdi_s;
  wire        fault_s;

  pin_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_async   ({i_rset_low_fault, i_sdi, i_sclk, !i_cs_n}),
    .o_sync    (pins_sync)
  );

  // Select is synchronised inverted, so a cleared stage reads deselected.
  assign cs_n_s  = !pins_sync[0];
  assign sclk_s  = pins_sync[1];
  assign sdi_s   = pins_sync[2];
  assign fault_s = pins_sync[3];

  // ----------------------------------------------------------------------
  // Registers and serial state
  // ----------------------------------------------------------------------
  logic       [7:0] config_a;
  logic       [7:0] config_b;
  logic       [7:0] reference;
  logic       [7:0] monitor;
  spi_state_t       state;
  logic             sclk_prev;
  logic             cs_n_prev;
  logic       [2:0] bit_cnt;
  logic       [7:0] shift_in;
  logic             rw;
  logic       [6:0] addr;
  logic             load_pending;
  logic       [7:0] out_shift;

  // ----------------------------------------------------------------------
  // Serial decode
  // ----------------------------------------------------------------------
  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_fall;
  wire        byte_done;
  wire  [7:0] next_shift_in;
  wire        addr_up;
  wire        single_instr;
  wire  [7:0] read_byte;
  wire  [7:0] status;

  assign sclk_rise     = !cs_n_s && !sclk_prev && sclk_s;
  assign sclk_fall     = !cs_n_s && sclk_prev && !sclk_s;
  assign cs_fall       = cs_n_prev && !cs_n_s;
  assign byte_done     = sclk_rise && (bit_cnt == 3'h7);
  assign next_shift_in = {shift_in[6:0], sdi_s};
  assign addr_up       = config_a[CFGA_DIR_HI_BIT] &&
                         config_a[CFGA_DIR_LO_BIT];
  assign single_instr  = config_b[CFGB_SINGLE_BIT];

  // ----------------------------------------------------------------------
  // Write path through the FIFO
  // ----------------------------------------------------------------------
  wire                  push_valid;
  wire                  push_ready;
  wire [FIFO_WIDTH-1:0] push_data;
  wire                  pop_valid;
  wire                  pop_ready;
  wire [FIFO_WIDTH-1:0] pop_data;
  wire            [6:0] wr_addr;
  wire            [7:0] wr_data;

  // Only whole write bytes enter, so a partial word never commits.
  assign push_valid = byte_done && (state == ST_DATA) && !rw;
  assign push_data  = {addr, next_shift_in};
  assign pop_ready  = !i_commit_hold;
  assign wr_addr    = pop_data[FIFO_WIDTH-1:DATA_W];
  assign wr_data    = pop_data[DATA_W-1:0];

  write_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_write_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_data),
    .o_out_valid (pop_valid),
    .i_out_ready (pop_ready),
    .o_out_data  (pop_data)
  );

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  wire        res_external;

  assign res_external = reference[REF_RES_BIT] && !fault_s;

  assign status = (8'h01 << STAT_FAULT_BIT)   & {8{fault_s}}
                | (8'h01 << STAT_RES_EXT_BIT) & {8{res_external}}
                | (8'h01 << STAT_EMPTY_BIT)   & {8{!pop_valid}};

  assign read_byte = (addr == ADDR_CONFIG_A)  ? config_a  :
                     (addr == ADDR_CONFIG_B)  ? config_b  :
                     (addr == ADDR_REFERENCE) ? reference :
                     (addr == ADDR_MONITOR)   ? monitor   :
                     (addr == ADDR_STATUS)    ? status    : 8'h00;

  // ----------------------------------------------------------------------
  // Serial state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state        <= ST_IDLE;
      sclk_prev    <= 1'h0;
      cs_n_prev    <= 1'h1;
      bit_cnt      <= 3'h0;
      shift_in     <= 8'h00;
      rw           <= 1'h0;
      addr         <= 7'h00;
      load_pending <= 1'h0;
    end else if (i_ce) begin
      sclk_prev <= sclk_s;
      cs_n_prev <= cs_n_s;
      if (cs_n_s) begin
        // Select high drops any partial instruction or word.
        state        <= ST_IDLE;
        bit_cnt      <= 3'h0;
        load_pending <= 1'h0;
      end else if (cs_fall) begin
        state   <= ST_INSTR;
        bit_cnt <= 3'h0;
      end else if (sclk_rise) begin
        shift_in <= next_shift_in;
        bit_cnt  <= 3'(bit_cnt + 3'h1);
        if (byte_done) begin
          case (state)
            ST_INSTR: begin
              rw           <= next_shift_in[7];
              addr         <= next_shift_in[6:0];
              state        <= ST_DATA;
              load_pending <= 1'h1;
            end
            ST_DATA: begin
              addr <= step_addr(addr, addr_up);
              if (single_instr) begin
                state        <= ST_INSTR;
                load_pending <= 1'h0;
              end else begin
                load_pending <= 1'h1;
              end
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end
      end else if (sclk_fall && (state == ST_DATA) && rw) begin
        load_pending <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data output
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_shift <= 8'h00;
      o_sdo     <= 1'h0;
      o_sdo_oe  <= 1'h0;
    end else if (i_ce) begin
      o_sdo_oe <= !cs_n_s;
      if (cs_n_s) begin
        o_sdo <= 1'h0;
      end else if (sclk_fall && (state == ST_DATA) && rw) begin
        if (load_pending) begin
          o_sdo     <= read_byte[7];
          out_shift <= {read_byte[6:0], 1'h0};
        end else begin
          o_sdo     <= out_shift[7];
          out_shift <= {out_shift[6:0], 1'h0};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  wire        commit;

  assign commit = pop_valid && pop_ready;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      config_a  <= CFGA_RESET;
      config_b  <= CFGB_RESET;
      reference <= REF_RESET;
      monitor   <= MON_RESET;
    end else if (i_ce && commit) begin
      case (wr_addr)
        ADDR_CONFIG_A: begin
          config_a <= wr_data & CFGA_MASK;
        end
        ADDR_CONFIG_B: begin
          config_b <= wr_data & CFGB_MASK;
        end
        ADDR_REFERENCE: begin
          reference <= wr_data & REF_MASK;
        end
        ADDR_MONITOR: begin
          monitor <= wr_data & MON_MASK;
        end
        default: begin
          config_a <= config_a;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Analog switch and monitor controls
  // ----------------------------------------------------------------------
  wire  [1:0] ref_sel;
  wire  [1:0] mon_func;
  wire        next_internal_ref_enable;
  wire        next_ref_output_switch;
  wire        next_internal_ref_switch;
  wire        next_divider_select_switch;
  wire        next_monitor_enable;

  assign ref_sel  = reference[REF_SEL_LSB +: 2];
  assign mon_func = monitor[MON_FUNC_LSB +: 2];

  assign next_internal_ref_enable   = is_internal(ref_sel);
  assign next_ref_output_switch     = (ref_sel == REF_INT_EXPORT) ||
                                      (ref_sel == REF_EXT_1V25);
  assign next_internal_ref_switch   = is_internal(ref_sel);
  // High points the divider switch at the reference node, low at the
  // resistor divider that halves an external 2.5 V reference.
  assign next_divider_select_switch = (ref_sel != REF_EXT_2V5);
  assign next_monitor_enable        = (mon_func != MON_OFF);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wr_fifo_ready            <= 1'h0;
      o_internal_ref_enable      <= 1'h0;
      o_ref_output_switch        <= 1'h0;
      o_internal_ref_switch      <= 1'h0;
      o_divider_select_switch    <= 1'h0;
      o_resistor_select_switch   <= 1'h0;
      o_monitor_enable           <= 1'h0;
      o_monitor_function_select  <= 2'h0;
      o_monitored_channel_select <= 3'h0;
      o_mux_buffer_enable        <= 1'h0;
      o_external_bias_enable     <= 1'h0;
    end else if (i_ce) begin
      o_wr_fifo_ready            <= push_ready;
      o_internal_ref_enable      <= next_internal_ref_enable;
      o_ref_output_switch        <= next_ref_output_switch;
      o_internal_ref_switch      <= next_internal_ref_switch;
      o_divider_select_switch    <= next_divider_select_switch;
      o_resistor_select_switch   <= res_external;
      o_monitor_enable           <= next_monitor_enable;
      // Voltage, current and temperature routing follow the function code.
      o_monitor_function_select  <= mon_func;
      o_monitored_channel_select <= monitor[MONITORED_CHANNEL_SELECT_LSB +: 3];
      o_mux_buffer_enable        <= monitor[MON_BUF_BIT];
      o_external_bias_enable     <= monitor[MON_BIAS_BIT];
    end
  end

endmodule // spi_reference_monitor_ctrl
`default_nettype wire

/* File: rtl/write_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module write_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  wire              push;
  wire              load;

  assign o_in_ready = (count != FULL_COUNT);
  assign push       = i_in_valid && o_in_ready;
  assign load       = (count != '0) && (!o_out_valid || i_out_ready);

  // ----------------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // ----------------------------------------------------------------------
  // Pointers and registered output stage
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      o_out_valid <= 1'h0;
      o_out_data  <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= PTR_W'(wr_ptr + 1'h1);
      end
      if (load) begin
        rd_ptr      <= PTR_W'(rd_ptr + 1'h1);
        o_out_data  <= mem[rd_ptr];
        o_out_valid <= 1'h1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'h0;
      end
      if (push && !load) begin
        count <= CNT_W'(count + 1'h1);
      end else if (load && !push) begin
        count <= CNT_W'(count - 1'h1);
      end
    end
  end

endmodule // write_fifo
`default_nettype wire

/* File: tb/spi_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end
  // Clock stands low outside frames; offset keeps it unrelated in phase.
  task automatic start();
    #83 o_cs_n = 1'b0;
    #80;
  endtask
  // Shifts n bits MSB first; both sides sample on the rising edge.
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_sdi = tx[i];
      #80 o_sclk = 1'b1;
      rx[i] = i_sdo;
      #80 o_sclk = 1'b0;
    end
  endtask
  task automatic stop();
    #80 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #400;
  endtask
endmodule // spi_host_model
`default_nettype wire

/* File: tb/spi_ref_mon_props.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_ref_mon_props
  import spi_ref_mon_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic       i_cs_n,
  input wire logic       i_sclk,
  input wire logic       i_rset_low_fault,
  input wire logic       o_sdo,
  input wire logic       o_sdo_oe,
  input wire logic       o_internal_ref_enable,
  input wire logic       o_ref_output_switch,
  input wire logic       o_internal_ref_switch,
  input wire logic       o_divider_select_switch,
  input wire logic       o_resistor_select_switch,
  input wire logic       o_monitor_enable,
  input wire logic [1:0] o_monitor_function_select
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------------
  // Reference, resistor and monitor steering
  // ----------------------------------------------------------------------
  chk_int_ref_power: assert property (
    o_internal_ref_enable == o_internal_ref_switch)
    else $error("internal reference power differs from its switch");
  chk_ext_divider: assert property (
    !o_divider_select_switch |-> !o_ref_output_switch && !o_internal_ref_switch)
    else $error("divider path with a reference switch closed");
  chk_int_ref_div: assert property (
    o_internal_ref_switch |-> o_divider_select_switch)
    else $error("internal reference without divider switch toward it");
  chk_mon_enable: assert property (
    o_monitor_enable == (o_monitor_function_select != 2'h0))
    else $error("monitor enable disagrees with function field");
  chk_res_fallback: assert property (
    i_rset_low_fault [*5] |-> !o_resistor_select_switch)
    else $error("external resistor kept under low resistance fault");
  // ----------------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------------
  chk_sdo_idle: assert property (
    i_cs_n [*8] |-> !o_sdo && !o_sdo_oe)
    else $error("serial output active while deselected");
  chk_oe_on_cs: assert property (
    $fell(i_cs_n) |-> ##[1:4] o_sdo_oe)
    else $error("serial output not enabled after select");
  chk_sdo_on_fall: assert property (
    $changed(o_sdo) && o_sdo_oe |-> !i_sclk)
    else $error("serial output changed while clock high");
  cover property ($fell(o_sdo_oe));
  cover property (o_internal_ref_enable && !o_ref_output_switch);
  cover property ($fell(o_resistor_select_switch));
endmodule // spi_ref_mon_props
bind spi_reference_monitor_ctrl spi_ref_mon_props u_props (
  .i_ref_clk, .i_rst_n, .i_cs_n, .i_sclk, .i_rset_low_fault, .o_sdo,
  .o_sdo_oe, .o_internal_ref_enable, .o_ref_output_switch,
  .o_internal_ref_switch, .o_divider_select_switch,
  .o_resistor_select_switch, .o_monitor_enable, .o_monitor_function_select
);
`default_nettype wire

/* File: tb/spi_reference_monitor_ctrl_test.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  mismatches++; $display("wrong value at %0t: %h, want %h", $time, got, exp); \
  end end
module spi_reference_monitor_ctrl_test;
  import spi_ref_mon_pkg::*;
  logic       i_ref_clk, i_rst_n, i_rset_low_fault, i_commit_hold;
  logic       cs_n, sclk, sdi, o_sdo, o_sdo_oe, o_wr_fifo_ready;
  logic       ref_en, ref_out, int_sw, div_sw, res_sw, mon_en, buf_en, bias;
  logic [1:0] mon_func;
  logic [2:0] monitored_channel_select;
  logic [7:0] rx, rx2;
  logic [3:0] ref_tbl [4] = '{4'b0101, 4'b0000, 4'b1111, 4'b1011};
  int         mismatches, check_count, cycles;
  spi_host_model host (.o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi),
                       .i_sdo(o_sdo));
  spi_reference_monitor_ctrl DUT (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_sdi(sdi), .i_rset_low_fault(i_rset_low_fault),
    .i_commit_hold(i_commit_hold), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_wr_fifo_ready(o_wr_fifo_ready), .o_internal_ref_enable(ref_en),
    .o_ref_output_switch(ref_out), .o_internal_ref_switch(int_sw),
    .o_divider_select_switch(div_sw), .o_resistor_select_switch(res_sw),
    .o_monitor_enable(mon_en), .o_monitor_function_select(mon_func),
    .o_monitored_channel_select(monitored_channel_select), .o_mux_buffer_enable(buf_en),
    .o_external_bias_enable(bias));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic settle();
    repeat (10) @(negedge i_ref_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.start();
    host.xfer({1'b0, a}, 8, rx);
    host.xfer(d, 8, rx);
    host.stop();
    settle();
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host.start();
    host.xfer({1'b1, a}, 8, rx);
    host.xfer(8'h00, 8, d);
    host.stop();
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_rset_low_fault = 1'b0;
    i_commit_hold = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    settle();
    `CHECK({ref_en, ref_out, int_sw, div_sw}, 4'b0000)
    `CHECK({res_sw, mon_en, buf_en, o_wr_fifo_ready}, 4'b0001)
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_REFERENCE, 8'(s << 1));
      `CHECK({ref_en, ref_out, int_sw, div_sw}, ref_tbl[s])
    end
    wr(ADDR_REFERENCE, 8'h05);
    rd(ADDR_REFERENCE, rx2);
    `CHECK(rx2, 8'h05)
    `CHECK(res_sw, 1'b1)
    i_rset_low_fault = 1'b1;
    settle();
    `CHECK(res_sw, 1'b0)
    i_rset_low_fault = 1'b0;
    $display("test reference done");
    for (int f = 1; f < 4; f++) begin
      // Buffer stays bypassed while external bias serves temperature mode.
      wr(ADDR_MONITOR,
         8'((f << 6) | ((f[0] ^ f[1]) << 5) | (f[1] << 4) | f));
      `CHECK({mon_en, mon_func, monitored_channel_select}, {1'b1, 2'(f), 3'(f)})
      `CHECK({buf_en, bias}, {f[0] ^ f[1], f[1]})
    end
    $display("test monitor done");
    host.start();
    host.xfer(8'h1A, 5, rx);
    host.stop();
    host.start();
    host.xfer({1'b0, ADDR_MONITOR}, 8, rx);
    host.xfer(8'hFF, 4, rx);
    host.stop();
    settle();
    `CHECK(mon_func, 2'h3)
    host.start();
    host.xfer({1'b0, ADDR_MONITOR}, 8, rx);
    host.xfer(8'h42, 8, rx);
    host.xfer(8'hFF, 4, rx);
    host.stop();
    settle();
    `CHECK({mon_func, buf_en, monitored_channel_select}, 6'h12)
    host.start();
    host.xfer({1'b1, ADDR_STATUS}, 8, rx);
    host.xfer(8'h00, 8, rx);
    host.xfer(8'h00, 8, rx2);
    host.stop();
    `CHECK(rx2, 8'h42)
    `CHECK(rx, 8'h06)
    wr(ADDR_CONFIG_A, 8'h24);
    host.start();
    host.xfer({1'b1, 7'h13}, 8, rx);
    host.xfer(8'h00, 8, rx);
    host.xfer(8'h00, 8, rx2);
    host.stop();
    `CHECK({rx, rx2}, 16'h0005)
    wr(ADDR_CONFIG_A, 8'h00);
    $display("test framing done");
    wr(ADDR_CONFIG_B, 8'h80);
    host.start();
    host.xfer({1'b0, ADDR_MONITOR}, 8, rx);
    host.xfer(8'h67, 8, rx);
    host.xfer({1'b1, ADDR_MONITOR}, 8, rx);
    host.xfer(8'h00, 8, rx2);
    host.stop();
    `CHECK(rx2, 8'h67)
    i_commit_hold = 1'b1;
    host.start();
    for (int i = 0; i < 18; i++) begin
      host.xfer({1'b0, ADDR_MONITOR}, 8, rx);
      host.xfer(8'h81, 8, rx);
    end
    host.stop();
    `CHECK({o_wr_fifo_ready, mon_func}, 3'b001)
    i_commit_hold = 1'b0;
    repeat (60) @(negedge i_ref_clk);
    `CHECK({o_wr_fifo_ready, mon_func}, 3'b110)
    wr(ADDR_CONFIG_B, 8'h00);
    $display("test buffering done");
    results();
  end
endmodule // spi_reference_monitor_ctrl_test
`default_nettype wire
